// >>> bench/pattern_seq_chk.sv
// Assertion checker for the pattern sequence block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pattern_seq_chk #(parameter N = 8, parameter IW = 3, parameter TW = 24) (
  input wire logic            i_mclk, i_rst, i_source_video, i_trig_mode_vsync, i_repeat, i_start,
  input wire logic            i_sequence_run_input, i_pattern_advance_input, i_vsync,
  input wire logic [IW-1:0]   i_last_index, o_pattern_index,
  input wire logic [TW-1:0]   i_exposure_us, i_period_us,
  input wire logic [N-1:0]    i_entry_ext_trig,
  input wire logic [N*6-1:0]  i_entry_image,
  input wire logic            o_running, o_pattern_on, o_frame_take, o_pattern_start,
  input wire logic [5:0]      o_image_index
);
  // Cycles since the last pattern start, so exposure and spacing are checked exactly.
  logic [31:0]   gap_ff;
  logic [IW-1:0] last_ff;
  logic          paused_ff;
  wire           vid = i_source_video | i_trig_mode_vsync;
  always_ff @(posedge i_mclk) begin
    gap_ff <= (i_rst | o_pattern_start) ? 32'h1 : gap_ff + 32'h1;
    last_ff <= i_rst ? '0 : (o_pattern_start ? o_pattern_index : last_ff);
    paused_ff <= (i_rst | o_pattern_start) ? 1'b0 : (paused_ff | !i_sequence_run_input);
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_start_one_cycle: assert property (o_pattern_start |=> !o_pattern_start)
    else $error("pattern start pulse too long");
  chk_take_one_cycle: assert property (o_frame_take |=> !o_frame_take)
    else $error("frame take pulse too long");
  chk_take_video_only: assert property (o_frame_take |-> vid)
    else $error("frame take outside frame-sync use");
  chk_start_opens_on: assert property (o_pattern_start |-> o_pattern_on && o_running)
    else $error("pattern start without exposure");
  chk_on_inside_run: assert property (o_pattern_on |-> o_running)
    else $error("exposure while not running");
  chk_image_of_entry: assert property (o_pattern_start |-> o_image_index == i_entry_image[o_pattern_index*6 +: 6])
    else $error("wrong image for entry");
  chk_exposure_exact: assert property ($fell(o_pattern_on) |-> gap_ff == i_exposure_us * 200)
    else $error("exposure length wrong");
  chk_period_exact: assert property (o_pattern_start && !vid && !i_entry_ext_trig[o_pattern_index]
    && o_pattern_index != 0 && !paused_ff |-> gap_ff == i_period_us * 200)
    else $error("internal period wrong");
  chk_frame_back_to_back: assert property (o_pattern_start && vid && o_pattern_index != 0
    |-> gap_ff == i_exposure_us * 200)
    else $error("frame patterns not back to back");
  chk_list_in_order: assert property (o_pattern_start && o_pattern_index != 0
    |-> o_pattern_index == IW'(last_ff + 1'b1))
    else $error("list order broken");
endmodule // pattern_seq_chk
bind pattern_sequence_trigger_timing pattern_seq_chk #(.N(N), .IW(IW), .TW(TW)) pattern_seq_chk_inst (.*);

// >>> bench/tb_top.sv
// Self-checking bench for the pattern sequence block and its trigger partner.
// Assumes a 200 MHz clock; exposure and period are a few microseconds.
`timescale 1ns/1ps
module tb_top;
  logic        i_mclk = 1'b0, i_rst = 1'b1, i_source_video = 1'b0, i_trig_mode_vsync = 1'b0;
  logic        i_repeat = 1'b0, i_start = 1'b0;
  logic [2:0]  i_last_index = 3'h2;
  logic [23:0] i_exposure_us = 24'h1, i_period_us = 24'h2;
  logic [7:0]  i_entry_ext_trig = 8'h04;
  logic [47:0] i_entry_image = 48'h3ef8_f3cc_b2a9;
  wire         run, adv, vs, o_running, o_pattern_on, o_frame_take, o_pattern_start;
  wire [2:0]   o_pattern_index;
  wire [5:0]   o_image_index;
  int          num_errors = 0, checked = 0, takes = 0;
  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (o_frame_take === 1'b1) takes++;
  trigger_partner trigger_partner_inst (.i_mclk(i_mclk), .o_run(run), .o_advance(adv), .o_vsync(vs));
  pattern_sequence_trigger_timing pattern_sequence_trigger_timing_inst (.*, .i_sequence_run_input(run),
    .i_pattern_advance_input(adv), .i_vsync(vs));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wait_start(input logic [2:0] idx);
    int n = 0;
    while (o_pattern_start !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    check(o_pattern_start, 1'b1);
    check(o_pattern_index, idx);
    check(o_image_index, i_entry_image[idx*6 +: 6]);
    tick(1);
  endtask
  task automatic do_reset();
    i_rst = 1'b1;
    tick(4);
    i_rst = 1'b0;
    check(o_running, 1'b0);
  endtask
  task automatic test_int_ext();
    trigger_partner_inst.set_run(1'b1);
    i_start = 1'b1;
    wait_start(3'h0);
    i_start = 1'b0;
    wait_start(3'h1);
    trigger_partner_inst.pulse(1'b0, 3);
    wait_start(3'h2);
    tick(420);
    check(o_running, 1'b0);
    $display("test int_ext done");
  endtask
  task automatic test_repeat();
    i_entry_ext_trig = 8'h00;
    i_repeat = 1'b1;
    i_start = 1'b1;
    wait_start(3'h0);
    i_start = 1'b0;
    wait_start(3'h1);
    trigger_partner_inst.set_run(1'b0);
    tick(600);
    check(o_pattern_index, 3'h1);
    trigger_partner_inst.set_run(1'b1);
    wait_start(3'h2);
    wait_start(3'h0);
    do_reset();
    $display("test repeat done");
  endtask
  task automatic test_frame();
    i_repeat = 1'b0;
    i_source_video = 1'b1;
    i_start = 1'b1;
    trigger_partner_inst.pulse(1'b1, 2);
    wait_start(3'h0);
    wait_start(3'h1);
    wait_start(3'h2);
    tick(200);
    trigger_partner_inst.pulse(1'b1, 2);
    wait_start(3'h0);
    i_start = 1'b0;
    check(takes, 2);
    i_trig_mode_vsync = 1'b1;
    i_source_video = 1'b0;
    tick(400);
    trigger_partner_inst.pulse(1'b1, 2);
    wait_start(3'h0);
    wait_start(3'h1);
    check(takes, 3);
    $display("test frame done");
  endtask
  task automatic print_verdict();
    $display("checked %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    do_reset();
    test_int_ext();
    test_repeat();
    test_frame();
    print_verdict();
  end
  initial begin
    #60000;
    num_errors++;
    print_verdict();
  end
endmodule // tb_top

// >>> bench/trigger_partner.sv
// Model of the camera or external system that drives the trigger pins.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`timescale 1ns/1ps
module trigger_partner (
  input  wire logic i_mclk,
  output logic      o_run,
  output logic      o_advance,
  output logic      o_vsync
);
  initial begin
    o_run = 1'b0;
    o_advance = 1'b0;
    o_vsync = 1'b0;
  end
  task automatic set_run(input logic v);
    @(posedge i_mclk);
    #1 o_run = v;
  endtask
  // Frames are spaced by the caller beyond the list's total exposure, except the last one in test_frame, which comes during the third pattern.
  // The 230 us load margin is not kept, to keep the run short.
  // Frames stand for 912 by 1140 pixels; only their sync edge reaches the block.
  task automatic pulse(input logic frame, input int hi);
    @(posedge i_mclk);
    #1;
    if (frame) o_vsync = 1'b1;
    else o_advance = 1'b1;
    repeat (hi) @(posedge i_mclk);
    #1 o_vsync = 1'b0;
    o_advance = 1'b0;
  endtask
endmodule // trigger_partner

// >>> rtl/pattern_seq_defines.vh
// Constants for the pattern sequence timing and trigger block.
// Assumes a 200 MHz system clock; included by the block's design file.
`ifndef PATTERN_SEQ_DEFINES_VH
`define PATTERN_SEQ_DEFINES_VH
`define CLK_MHZ           200
`define US_CYCLES         (`CLK_MHZ)
`define MAX_IMAGES        64
`define IMG_IDX_W         6
`define IMG_DEPTH_BITS    24
`define TIME_W            24
`define LIST_LEN          8
`define LIST_IDX_W        3
`define SRC_FLASH         1'b0
`define SRC_VIDEO         1'b1
`define TMODE_INT_EXT     1'b0
`define TMODE_VSYNC       1'b1
`define PTRIG_INTERNAL    1'b0
`define PTRIG_EXTERNAL    1'b1
`endif

// >>> rtl/pattern_sequence_trigger_timing.v
// Pattern sequence timing and trigger logic: steps an ordered pattern list,
// timing exposure and period in microseconds from a divided system clock.
// Assumes configuration inputs are static while running; pins are asynchronous.
//
// Operation
// RULE_01: The pattern source image index selects one of at most sixty-four stored 24-bit images.
// RULE_02: The outside system drives only one of the two video interfaces while video is the source.
// RULE_03: In internal/external mode the sequence starts on the internal period or runs while the run input is high.
// RULE_04: Each list entry carries its own internal or external trigger selection.
// RULE_05: An internally triggered entry is advanced to when the internal period elapses.
// RULE_06: An externally triggered entry is advanced to on a rising edge of the advance input.
// RULE_07: In frame-sync mode the sequence begins on the frame-sync edge.
// RULE_08: After each frame-sync the listed patterns are shown one after another in order.
// RULE_09: In frame-sync mode each pattern is shown for exactly the exposure time.
// RULE_10: The configuring party keeps pattern count times exposure within the frame-sync period.
// RULE_11: The exposure setting is held in microseconds and sets how long a pattern is shown.
// RULE_12: The period setting is held in microseconds and sets start-to-start spacing.
// RULE_13: The configuring party keeps the period at least 230 us above the exposure.
// RULE_14: With the video port as source the frame-sync edge is always the trigger and takes a new frame.
// RULE_15: The list is played once then stops, or repeated continuously.
// RULE_16: A video source supplies 912 by 1140 pixel frames.
// RULE_17: A one-microsecond tick times exposure and period with counters reloaded at each pattern start.
`timescale 1ns/1ps
`include "pattern_seq_defines.vh"

module pattern_sequence_trigger_timing #(
  parameter N      = `LIST_LEN,
  parameter IW     = `LIST_IDX_W,
  parameter TW     = `TIME_W
) (
  // Clock and reset
  input  wire              i_mclk,
  input  wire              i_rst,
  // Configuration
  input  wire              i_source_video,
  input  wire              i_trig_mode_vsync,
  input  wire              i_repeat,
  input  wire [IW-1:0]     i_last_index,
  input  wire [TW-1:0]     i_exposure_us,
  input  wire [TW-1:0]     i_period_us,
  input  wire [N-1:0]      i_entry_ext_trig,
  input  wire [N*6-1:0]    i_entry_image,
  input  wire              i_start,
  // Pins
  input  wire              i_sequence_run_input,
  input  wire              i_pattern_advance_input,
  input  wire              i_vsync,
  // Outputs
  output reg               o_running,
  output reg               o_pattern_on,
  output reg  [IW-1:0]     o_pattern_index,
  output reg  [5:0]        o_image_index,
  output reg               o_frame_take,
  output reg               o_pattern_start
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_SHOW = 2'd2;
  localparam [7:0] US_DIV = `US_CYCLES;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read by logic.
  reg [1:0] run_sync_ff;
  reg [1:0] adv_sync_ff;
  reg [1:0] vs_sync_ff;
  reg       adv_d_ff;
  reg       vs_d_ff;
  always @(posedge i_mclk) begin
    if (i_rst) begin
      run_sync_ff <= 2'b00;
      adv_sync_ff <= 2'b00;
      vs_sync_ff  <= 2'b00;
      adv_d_ff    <= 1'b0;
      vs_d_ff     <= 1'b0;
    end else begin
      run_sync_ff <= {run_sync_ff[0], i_sequence_run_input};
      adv_sync_ff <= {adv_sync_ff[0], i_pattern_advance_input};
      vs_sync_ff  <= {vs_sync_ff[0], i_vsync};
      adv_d_ff    <= adv_sync_ff[1];
      vs_d_ff     <= vs_sync_ff[1];
    end
  end
  wire run_lvl  = run_sync_ff[1];
  wire adv_rise = adv_sync_ff[1] & ~adv_d_ff;
  wire vs_rise  = vs_sync_ff[1] & ~vs_d_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Microsecond tick; it restarts with each pattern so timing is exact to the clock cycle.
  reg  [7:0] div_ff;
  reg        restart;
  wire       tick = (div_ff == US_DIV - 8'd1);
  always @(posedge i_mclk) begin
    if (i_rst || restart)
      div_ff <= 8'h00;
    else if (tick)
      div_ff <= 8'h00;
    else
      div_ff <= div_ff + 8'h01;                                       // RULE_17
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state and timing registers.
  reg [1:0]    st_ff;
  reg [TW-1:0] exp_cnt_ff;
  reg [TW-1:0] per_cnt_ff;
  reg          per_done_ff;
  reg          adv_pend_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Step decisions.
  wire          video_mode = i_source_video | i_trig_mode_vsync;                  // RULE_14
  wire          idle       = (st_ff == ST_IDLE);
  wire          last       = (o_pattern_index == i_last_index);
  wire [IW-1:0] nxt_idx    = last ? {IW{1'b0}} : o_pattern_index + {{(IW-1){1'b0}}, 1'b1};
  wire          nxt_ext    = (i_entry_ext_trig[nxt_idx] == `PTRIG_EXTERNAL);      // RULE_04
  wire          wrap_stop  = last & ~i_repeat & ~video_mode;                       // RULE_15

  // The period ends in the cycle of its last tick, so that the next start lands
  // exactly one period after the one before rather than one cycle late.
  wire          per_end    = tick & (per_cnt_ff == {{(TW-1){1'b0}}, 1'b1});       // RULE_17
  wire          per_over   = per_done_ff | per_end;                               // RULE_12
  wire          exp_end    = tick & (exp_cnt_ff == {{(TW-1){1'b0}}, 1'b1});       // RULE_11

  // Starts and frame restarts.
  wire          ie_start   = idle & i_start & ~video_mode & run_lvl;              // RULE_03
  wire          vid_start  = idle & i_start & video_mode & vs_rise;               // RULE_07
  wire          vid_resync = ~idle & video_mode & vs_rise;                        // RULE_07 RULE_14

  // Outside frame-sync use, an entry's trigger type decides how the step into it is released
  // and a low run level holds the list on its current entry.
  wire          go_next    = video_mode ? per_over :                              // RULE_08
                             nxt_ext ? (per_over & adv_pend_ff & run_lvl) :       // RULE_06 RULE_03
                             (per_over & run_lvl);                                // RULE_05 RULE_03

  // Frame-sync stops at the last entry and waits for the next frame edge.
  wire          step       = ~idle & go_next & ~wrap_stop & ~(video_mode & last); // RULE_08
  wire          stop       = ~idle & per_over & wrap_stop;                        // RULE_15

  // Frame-sync restarts from the head of the list on every frame.
  wire [IW-1:0] start_idx  = (idle | vid_resync) ? {IW{1'b0}} : nxt_idx;          // RULE_07

  always @* begin
    restart = 1'b0;
    if (ie_start || vid_start)
      restart = 1'b1;
    if (vid_resync || step)
      restart = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Exposure and period counters; both reload at every pattern start.
  // They stop at zero, so a list held by a low run level cannot wrap them.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      exp_cnt_ff  <= {TW{1'b0}};
      per_cnt_ff  <= {TW{1'b0}};
      per_done_ff <= 1'b0;
    end else if (restart) begin
      exp_cnt_ff  <= i_exposure_us;                                       // RULE_11 RULE_17
      per_cnt_ff  <= video_mode ? i_exposure_us : i_period_us;            // RULE_09 RULE_12
      per_done_ff <= 1'b0;
    end else if (tick) begin
      if (exp_cnt_ff != {TW{1'b0}})
        exp_cnt_ff <= exp_cnt_ff - {{(TW-1){1'b0}}, 1'b1};
      if (per_cnt_ff != {TW{1'b0}})
        per_cnt_ff <= per_cnt_ff - {{(TW-1){1'b0}}, 1'b1};
      if (per_end)
        per_done_ff <= 1'b1;                                              // RULE_12
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Advance latch and one-cycle pulses.
  // Only one advance is remembered; an edge that meets a start is kept for the
  // next step, so a fast external trigger is never lost.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      adv_pend_ff     <= 1'b0;
      o_pattern_start <= 1'b0;
      o_frame_take    <= 1'b0;
    end else begin
      o_pattern_start <= restart;                                         // RULE_17
      o_frame_take    <= vid_start | vid_resync;                          // RULE_14
      if (adv_rise)
        adv_pend_ff <= 1'b1;                                              // RULE_06
      else if (restart)
        adv_pend_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state and displayed entry.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      st_ff           <= ST_IDLE;
      o_running       <= 1'b0;
      o_pattern_on    <= 1'b0;
      o_pattern_index <= {IW{1'b0}};
      o_image_index   <= 6'h00;
    end else if (restart) begin
      st_ff           <= ST_SHOW;
      o_running       <= 1'b1;
      o_pattern_on    <= 1'b1;                                            // RULE_11
      o_pattern_index <= start_idx;                                       // RULE_07 RULE_08
      o_image_index   <= i_entry_image[start_idx*6 +: 6];                 // RULE_01
    end else begin
      case (st_ff)
        ST_IDLE: begin
          o_running    <= 1'b0;
          o_pattern_on <= 1'b0;
        end
        ST_SHOW, ST_WAIT: begin
          if (exp_end)
            o_pattern_on <= 1'b0;                                         // RULE_09 RULE_11
          if (per_end)
            st_ff <= ST_WAIT;
          if (stop)
            st_ff <= ST_IDLE;                                             // RULE_15
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pattern_sequence_trigger_timing
